// ### design/link_timing_pkg.sv
// Shared constants, carrier types and states for the serial link receive timing block
//
// Contract
// R1: While the low-power driver drives a line high but the pin reads low, a high contention fault is flagged.
// R2: While the low-power driver drives a line low but the pin is above the contention threshold, a low fault is flagged.
// R3: The link master is the only clock source in both directions, and the clock always travels forward.
// R4: The master forwards a half-rate clock with one transition per data bit, so one period spans two bits.
// R5: Lane data is captured on both rising and falling edges of the forwarded clock, used directly as the strobe.
// R6: The first payload bit of a burst is taken on a rising edge, the second on the next falling edge, then alternating.
// R7: Bit-period jitter of the forwarded clock is absorbed by elastic buffering so the core sees a smooth data rate.
// R8: The host keeps every half cycle of the forwarded clock within a burst at or above 1.82 ns.
// R9: The host stays at or below 550 Mbps per lane when two lanes carry 24-bit pixels.
// R10: In video mode vertical sync lasts at least 2 lines and each vertical porch is at least 2 lines.
// R11: Each frame carries 320 active lines, at least 6 lines of vertical blanking, at a nominal 60 Hz. The frame rate is not checked.
// R12: Horizontal sync lasts 6 to 78 pixel clocks, a line holds 240 active pixel clocks, and sync plus back porch exceeds 0.5 us.
// R13: Each horizontal porch lasts 5 to 78 pixel clocks, total blanking 16 to 88, and the front porch exceeds 0.5 us.
// R14: Horizontal intervals are counted in pixel clocks, vertical ones in lines, and any violation raises a timing error.
package link_timing_pkg;

	localparam int CLOCK_MHZ      = 40;
	localparam int HALF_US_NS     = 500;
	localparam int HALF_US_CYCLES = HALF_US_NS * CLOCK_MHZ / 1000;

	localparam int COUNT_WIDTH     = 11;
	localparam int SUM_WIDTH       = 13;
	localparam int BYTE_WIDTH      = 8;
	localparam int FIFO_ADDR_WIDTH = 2;
	localparam int SYNC_DEPTH      = 3;

	typedef logic [COUNT_WIDTH-1:0] count_type;

	localparam count_type HSYNC_MIN      = 11'h006;
	localparam count_type HSYNC_MAX      = 11'h04e;
	localparam count_type HPORCH_MIN     = 11'h005;
	localparam count_type HPORCH_MAX     = 11'h04e;
	localparam count_type HBLANK_MIN     = 11'h010;
	localparam count_type HBLANK_MAX     = 11'h058;
	localparam count_type HACTIVE_PIXELS = 11'h0f0;
	localparam count_type VSYNC_MIN      = 11'h002;
	localparam count_type VPORCH_MIN     = 11'h002;
	localparam count_type VBLANK_MIN     = 11'h006;
	localparam count_type VACTIVE_LINES  = 11'h140;
	localparam count_type COUNT_MAX      = 11'h7ff;

	localparam logic [1:0] LAST_PAIR = 2'h3;

	typedef struct packed {
		logic enable;
		logic level;
	} lp_drive_type;

	typedef struct packed {
		logic lp_high_fault;
		logic lp_low_fault;
		logic timing_error;
		logic fifo_overflow;
	} fault_type;

	typedef enum logic [2:0] {h_idle, h_sync, h_back, h_active, h_front} h_state_type;
	typedef enum logic [2:0] {v_idle, v_sync, v_back, v_active, v_front} v_state_type;

endpackage

// ### design/pair_buffer.sv
// Two-entry valid/ready buffer between the elastic store and the byte consumer
`timescale 1ns/1ps
`default_nettype none
module pair_buffer
#(
	parameter int WIDTH = 8
)
(
	input  wire logic             clock,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output var  logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output var  logic             out_valid,
	input  wire logic             out_ready,
	output var  logic [WIDTH-1:0] out_data
);
	logic             spare_valid;
	logic [WIDTH-1:0] spare_data;
	logic             next_out_valid;
	logic [WIDTH-1:0] next_out_data;
	logic             next_spare_valid;
	logic [WIDTH-1:0] next_spare_data;

	assign in_ready = !spare_valid;

	always_comb
	begin
		next_out_valid   = out_valid;
		next_out_data    = out_data;
		next_spare_valid = spare_valid;
		next_spare_data  = spare_data;
		if (out_valid && out_ready)
		begin
			next_out_valid   = spare_valid;
			next_out_data    = spare_data;
			next_spare_valid = 1'b0;
		end
		if (in_valid && !spare_valid)
		begin
			if (!next_out_valid)
			begin
				next_out_valid = 1'b1;
				next_out_data  = in_data;
			end
			else
			begin
				next_spare_valid = 1'b1;
				next_spare_data  = in_data;
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			out_valid   <= 1'b0;
			out_data    <= '0;
			spare_valid <= 1'b0;
			spare_data  <= '0;
		end
		else
		begin
			out_valid   <= next_out_valid;
			out_data    <= next_out_data;
			spare_valid <= next_spare_valid;
			spare_data  <= next_spare_data;
		end
	end

	a_no_loss_when_full : assert property (@(posedge clock) disable iff (!rstn)
		(out_valid && !out_ready && spare_valid) |=> (out_valid && spare_valid && $stable(out_data)))
		else $error("Buffer changed while stalled and full");

endmodule
`default_nettype wire

// ### design/serial_video_link_rx_timing.sv
// Link byte capture, elastic crossing, contention and video timing checks
`timescale 1ns/1ps
`default_nettype none
module serial_video_link_rx_timing
	import link_timing_pkg::*;
#(
	parameter count_type ACTIVE_PIXELS = HACTIVE_PIXELS,
	parameter count_type ACTIVE_LINES  = VACTIVE_LINES
)
(
	input  wire logic                  clock,
	input  wire logic                  rstn,
	input  wire logic                  link_clock,
	input  wire logic                  lane_data,
	input  wire logic                  lane_hs_active,
	input  wire lp_drive_type          lp_drive,
	input  wire logic                  pin_above_low_threshold,
	input  wire logic                  pin_above_contention,
	input  wire logic                  hsync_n,
	input  wire logic                  vsync_n,
	input  wire logic                  data_enable,
	input  wire logic                  clear_faults,
	output var  logic                  rx_valid,
	input  wire logic                  rx_ready,
	output var  logic [BYTE_WIDTH-1:0] rx_data,
	output var  fault_type             faults
);
	localparam int FIFO_DEPTH = 1 << FIFO_ADDR_WIDTH;
	typedef logic [FIFO_ADDR_WIDTH:0] ptr_type;

	function automatic ptr_type gray_to_bin(input ptr_type gray);
		ptr_type bin;
		bin[FIFO_ADDR_WIDTH] = gray[FIFO_ADDR_WIDTH];
		for (int i = FIFO_ADDR_WIDTH - 1; i >= 0; i--)
			bin[i] = bin[i+1] ^ gray[i];
		return bin;
	endfunction

	function automatic logic in_limits(input logic [SUM_WIDTH-1:0] value, input count_type lo, input count_type hi);
		return (value >= SUM_WIDTH'(lo)) && (value <= SUM_WIDTH'(hi));
	endfunction

	function automatic count_type sat_inc(input count_type value);
		return (value == COUNT_MAX) ? value : value + 11'h001;
	endfunction

	// Link domain, rising edge: reset sync, burst level, first bit of each pair
	logic [1:0] link_rst_pipe;
	logic       link_rstn;
	logic       in_burst;
	logic       rise_bit;
	logic [1:0] next_link_rst_pipe;
	logic       next_in_burst;
	logic       next_rise_bit;

	assign link_rstn = link_rst_pipe[1];

	always_comb
	begin
		next_link_rst_pipe = {link_rst_pipe[0], rstn};
		next_in_burst      = lane_hs_active;
		next_rise_bit      = lane_data;
	end

	always_ff @(posedge link_clock)
	begin
		link_rst_pipe <= next_link_rst_pipe;
		if (!link_rstn)
		begin
			in_burst <= 1'b0;
			rise_bit <= 1'b0;
		end
		else
		begin
			in_burst <= next_in_burst;
			rise_bit <= next_rise_bit; // [R5] [R6]
		end
	end

	// Link domain, falling edge: pair assembly and elastic store writes
	logic [BYTE_WIDTH-1:0] shift;
	logic [1:0]            pair_count;
	ptr_type               write_bin;
	ptr_type               write_gray;
	ptr_type               read_gray_meta;
	ptr_type               read_gray_sync;
	logic                  overflow_toggle;
	logic [BYTE_WIDTH-1:0] store [FIFO_DEPTH];
	logic [BYTE_WIDTH-1:0] next_shift;
	logic [1:0]            next_pair_count;
	ptr_type               next_write_bin;
	logic                  next_overflow_toggle;
	logic [BYTE_WIDTH-1:0] next_store [FIFO_DEPTH];
	ptr_type               read_bin_link;
	logic                  store_full;

	assign read_bin_link = gray_to_bin(read_gray_sync);
	assign store_full    = (write_bin[FIFO_ADDR_WIDTH-1:0] == read_bin_link[FIFO_ADDR_WIDTH-1:0])
		&& (write_bin[FIFO_ADDR_WIDTH] != read_bin_link[FIFO_ADDR_WIDTH]);

	always_comb
	begin
		next_shift           = shift;
		next_pair_count      = 2'h0;
		next_write_bin       = write_bin;
		next_overflow_toggle = overflow_toggle;
		next_store           = store;
		if (in_burst)
		begin
			// Rising-edge bit is the earlier one, so it lands below the falling-edge bit
			next_shift      = {lane_data, rise_bit, shift[BYTE_WIDTH-1:2]}; // [R5] [R6]
			next_pair_count = pair_count + 2'h1;
			if (pair_count == LAST_PAIR)
			begin
				if (!store_full)
				begin
					next_store[write_bin[FIFO_ADDR_WIDTH-1:0]] = next_shift; // [R7]
					next_write_bin = write_bin + ptr_type'(1);
				end
				else
					next_overflow_toggle = !overflow_toggle;
			end
		end
	end

	always_ff @(negedge link_clock)
	begin
		if (!link_rstn)
		begin
			shift           <= '0;
			pair_count      <= 2'h0;
			write_bin       <= '0;
			write_gray      <= '0;
			read_gray_meta  <= '0;
			read_gray_sync  <= '0;
			overflow_toggle <= 1'b0;
			for (int i = 0; i < FIFO_DEPTH; i++)
				store[i] <= '0;
		end
		else
		begin
			shift           <= next_shift;
			pair_count      <= next_pair_count;
			write_bin       <= next_write_bin;
			write_gray      <= next_write_bin ^ (next_write_bin >> 1);
			read_gray_meta  <= read_gray;
			read_gray_sync  <= read_gray_meta;
			overflow_toggle <= next_overflow_toggle;
			store           <= next_store;
		end
	end

	a_burst_starts_rising : assert property (@(negedge link_clock) disable iff (!link_rstn)
		!in_burst |=> (pair_count == 2'h0)) // [R6]
		else $error("Pair count not restarted outside a burst");

	a_both_edges_used : assert property (@(negedge link_clock) disable iff (!link_rstn)
		(in_burst && $past(in_burst) && $past(in_burst, 2))
			|-> (shift[BYTE_WIDTH-1] == $past(lane_data)) && (shift[BYTE_WIDTH-3] == $past(lane_data, 2))) // [R5]
		else $error("Falling-edge bits not shifted in pairs");

	a_full_blocks_write : assert property (@(negedge link_clock) disable iff (!link_rstn)
		(store_full && in_burst && pair_count == LAST_PAIR) |=> $stable(write_bin) && (overflow_toggle != $past(overflow_toggle))) // [R7]
		else $error("Write into full store or overflow not reported");

	// Core domain: read side of the elastic store and the pin synchronisers
	ptr_type                 read_bin;
	ptr_type                 read_gray;
	ptr_type                 write_gray_meta;
	ptr_type                 write_gray_sync;
	logic [2:0]              overflow_pipe;
	logic [SYNC_DEPTH-1:0]   high_pipe;
	logic [SYNC_DEPTH-1:0]   cd_pipe;
	logic                    pin_high;
	logic                    pin_over_cd;
	lp_drive_type            drive_pipe [SYNC_DEPTH];
	logic                    hsync_prev;
	logic                    vsync_prev;
	logic                    de_prev;
	ptr_type                 next_read_bin;
	logic                    next_pin_high;
	logic                    next_pin_over_cd;
	logic                    store_empty;
	logic                    buffer_ready;
	logic                    pop;

	assign store_empty = (read_bin == gray_to_bin(write_gray_sync));
	assign pop         = !store_empty && buffer_ready;

	always_comb
	begin
		next_read_bin    = pop ? read_bin + ptr_type'(1) : read_bin; // [R7]
		// A pin change counts once the last two stages agree
		next_pin_high    = (high_pipe[1] == high_pipe[2]) ? high_pipe[2] : pin_high;
		next_pin_over_cd = (cd_pipe[1] == cd_pipe[2]) ? cd_pipe[2] : pin_over_cd;
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			read_bin        <= '0;
			write_gray_meta <= '0;
			write_gray_sync <= '0;
			read_gray       <= '0;
			overflow_pipe   <= 3'h0;
			high_pipe       <= '0;
			cd_pipe         <= '0;
			pin_high        <= 1'b0;
			pin_over_cd     <= 1'b0;
			hsync_prev      <= 1'b1;
			vsync_prev      <= 1'b1;
			de_prev         <= 1'b0;
			for (int i = 0; i < SYNC_DEPTH; i++)
				drive_pipe[i] <= '0;
		end
		else
		begin
			read_bin        <= next_read_bin;
			read_gray       <= next_read_bin ^ (next_read_bin >> 1);
			write_gray_meta <= write_gray;
			write_gray_sync <= write_gray_meta;
			overflow_pipe   <= {overflow_pipe[1:0], overflow_toggle};
			high_pipe       <= {high_pipe[1:0], pin_above_low_threshold};
			cd_pipe         <= {cd_pipe[1:0], pin_above_contention};
			pin_high        <= next_pin_high;
			pin_over_cd     <= next_pin_over_cd;
			hsync_prev      <= hsync_n;
			vsync_prev      <= vsync_n;
			de_prev         <= data_enable;
			// Drive state delayed to line up with the pin synchroniser
			drive_pipe[0]   <= lp_drive;
			for (int i = 1; i < SYNC_DEPTH; i++)
				drive_pipe[i] <= drive_pipe[i-1];
		end
	end

	pair_buffer #(.WIDTH(BYTE_WIDTH)) output_buffer
	(
		.clock     (clock),
		.rstn      (rstn),
		.in_valid  (!store_empty),
		.in_ready  (buffer_ready),
		.in_data   (store[read_bin[FIFO_ADDR_WIDTH-1:0]]),
		.out_valid (rx_valid),
		.out_ready (rx_ready),
		.out_data  (rx_data)
	);

	// Horizontal timing in pixel clocks
	h_state_type h_state;
	count_type   h_count;
	count_type   h_sync_len;
	count_type   h_back_len;
	h_state_type next_h_state;
	count_type   next_h_count;
	count_type   next_h_sync_len;
	count_type   next_h_back_len;
	logic        h_violation;
	logic        hsync_fall;

	assign hsync_fall = hsync_prev && !hsync_n;

	always_comb
	begin
		next_h_state    = h_state;
		next_h_count    = sat_inc(h_count);
		next_h_sync_len = h_sync_len;
		next_h_back_len = h_back_len;
		h_violation     = 1'b0;
		if (hsync_fall)
		begin
			if (h_state == h_front)
				h_violation = !in_limits(SUM_WIDTH'(h_count), HPORCH_MIN, HPORCH_MAX) // [R13] [R14]
					|| (SUM_WIDTH'(h_count) <= SUM_WIDTH'(HALF_US_CYCLES))
					|| !in_limits(SUM_WIDTH'(h_sync_len) + SUM_WIDTH'(h_back_len) + SUM_WIDTH'(h_count),
						HBLANK_MIN, HBLANK_MAX);
			// A blank line legally ends in the back porch
			else if (h_state == h_active)
				h_violation = 1'b1;
			next_h_state = h_sync;
			next_h_count = 11'h001;
		end
		else
		begin
			unique case (h_state)
				h_sync:
				if (hsync_n)
				begin
					h_violation     = !in_limits(SUM_WIDTH'(h_count), HSYNC_MIN, HSYNC_MAX); // [R12] [R14]
					next_h_sync_len = h_count;
					next_h_state    = h_back;
					next_h_count    = 11'h001;
				end
				h_back:
				if (data_enable)
				begin
					h_violation     = !in_limits(SUM_WIDTH'(h_count), HPORCH_MIN, HPORCH_MAX) // [R13] [R14]
						|| (SUM_WIDTH'(h_sync_len) + SUM_WIDTH'(h_count) <= SUM_WIDTH'(HALF_US_CYCLES)); // [R12]
					next_h_back_len = h_count;
					next_h_state    = h_active;
					next_h_count    = 11'h001;
				end
				h_active:
				if (!data_enable)
				begin
					h_violation  = (h_count != ACTIVE_PIXELS); // [R12] [R14]
					next_h_state = h_front;
					next_h_count = 11'h001;
				end
				h_idle, h_front:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			h_state    <= h_idle;
			h_count    <= '0;
			h_sync_len <= '0;
			h_back_len <= '0;
		end
		else
		begin
			h_state    <= next_h_state;
			h_count    <= next_h_count;
			h_sync_len <= next_h_sync_len;
			h_back_len <= next_h_back_len;
		end
	end

	// Vertical timing in lines, a line starting at each sync fall
	v_state_type v_state;
	count_type   v_count;
	count_type   v_sync_len;
	count_type   v_back_len;
	count_type   v_active_count;
	logic        line_had_de;
	v_state_type next_v_state;
	count_type   next_v_count;
	count_type   next_v_sync_len;
	count_type   next_v_back_len;
	count_type   next_v_active_count;
	logic        next_line_had_de;
	logic        v_violation;

	always_comb
	begin
		next_v_state        = v_state;
		next_v_count        = hsync_fall ? sat_inc(v_count) : v_count;
		next_v_sync_len     = v_sync_len;
		next_v_back_len     = v_back_len;
		next_v_active_count = v_active_count;
		next_line_had_de    = hsync_fall ? 1'b0 : (line_had_de || data_enable);
		v_violation         = 1'b0;
		if (vsync_prev && !vsync_n)
		begin
			if (v_state == v_front)
				v_violation = (v_count < VPORCH_MIN) // [R10] [R14]
					|| (SUM_WIDTH'(v_sync_len) + SUM_WIDTH'(v_back_len) + SUM_WIDTH'(v_count)
						< SUM_WIDTH'(VBLANK_MIN)); // [R11]
			else if (v_state != v_idle)
				v_violation = 1'b1;
			next_v_state = v_sync;
			// Line starting with the sync fall is a sync line
			next_v_count = count_type'(hsync_fall);
		end
		else
		begin
			unique case (v_state)
				v_sync:
				if (vsync_n)
				begin
					v_violation     = (v_count < VSYNC_MIN); // [R10] [R14]
					next_v_sync_len = v_count;
					next_v_state    = v_back;
					next_v_count    = '0;
				end
				v_back:
				if (data_enable)
				begin
					v_violation         = (v_count < VPORCH_MIN); // [R10] [R14]
					next_v_back_len     = v_count;
					next_v_state        = v_active;
					next_v_active_count = 11'h001;
				end
				v_active:
				if (hsync_fall && !line_had_de)
				begin
					v_violation  = (v_active_count != ACTIVE_LINES); // [R11] [R14]
					next_v_state = v_front;
					// First blank line plus the one starting now
					next_v_count = 11'h002;
				end
				else if (data_enable && !de_prev)
					next_v_active_count = sat_inc(v_active_count);
				v_idle, v_front:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			v_state        <= v_idle;
			v_count        <= '0;
			v_sync_len     <= '0;
			v_back_len     <= '0;
			v_active_count <= '0;
			line_had_de    <= 1'b0;
		end
		else
		begin
			v_state        <= next_v_state;
			v_count        <= next_v_count;
			v_sync_len     <= next_v_sync_len;
			v_back_len     <= next_v_back_len;
			v_active_count <= next_v_active_count;
			line_had_de    <= next_line_had_de;
		end
	end

	// Sticky faults; a new event wins over a clear in the same cycle
	fault_type next_faults;
	fault_type fault_events;

	always_comb
	begin
		fault_events.lp_high_fault = drive_pipe[2].enable && drive_pipe[2].level && !pin_high; // [R1]
		fault_events.lp_low_fault  = drive_pipe[2].enable && !drive_pipe[2].level && pin_over_cd; // [R2]
		fault_events.timing_error  = h_violation || v_violation; // [R14]
		fault_events.fifo_overflow = overflow_pipe[2] != overflow_pipe[1];
		next_faults                = (clear_faults ? '0 : faults) | fault_events;
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
			faults <= '0;
		else
			faults <= next_faults;
	end

	a_high_contention : assert property (@(posedge clock) disable iff (!rstn)
		(drive_pipe[2].enable && drive_pipe[2].level && !pin_high) |=> faults.lp_high_fault) // [R1]
		else $error("High contention not flagged");

	a_low_contention : assert property (@(posedge clock) disable iff (!rstn)
		(drive_pipe[2].enable && !drive_pipe[2].level && pin_over_cd) |=> faults.lp_low_fault) // [R2]
		else $error("Low contention not flagged");

	a_hsync_width : assert property (@(posedge clock) disable iff (!rstn)
		(h_state == h_sync && hsync_n && h_count < HSYNC_MIN) |=> faults.timing_error) // [R14]
		else $error("Short horizontal sync not flagged");

	a_active_pixels : assert property (@(posedge clock) disable iff (!rstn)
		(h_state == h_active && !data_enable && !hsync_fall && h_count != ACTIVE_PIXELS)
			|=> faults.timing_error && (h_state == h_front)) // [R14]
		else $error("Wrong active pixel count not flagged");

endmodule
`default_nettype wire

// ### dv/host_link_model.sv
// Host link master model: forwarded DDR clock and one data lane
`timescale 1ns/1ps
`default_nettype none
module host_link_model
(
	input  wire logic free_run,
	output var  logic link_clock,
	output var  logic lane_data,
	output var  logic lane_hs_active
);
	logic [7:0] tx_q[$];
	logic       bursting = 1'b0;

	initial
	begin
		link_clock = 1'b0;
		lane_data = 1'b0;
		lane_hs_active = 1'b0;
	end

	// Runs free only while reset settles, then parks low
	always #7.5 if (!bursting && (free_run || link_clock)) link_clock = ~link_clock;

	// Sole clock source, one transition per bit, 7.5 ns bits
	task automatic send_burst();
		logic [7:0] b;
		bursting = 1'b1;
		lane_hs_active = 1'b1;
		while (tx_q.size() > 0)
		begin
			b = tx_q.pop_front();
			for (int i = 0; i < 8; i++)
			begin
				lane_data = b[i];
				#3.75 link_clock = ~link_clock;
				#3.75;
			end
		end
		lane_hs_active = 1'b0;
		lane_data = ~lane_data;
		// Trailing clock cycle shows the burst end to the receiver
		#3.75 link_clock = 1'b1;
		#7.5 link_clock = 1'b0;
		#3.75 bursting = 1'b0;
	endtask
endmodule
`default_nettype wire

// ### dv/serial_video_link_rx_timing_bench.sv
// Self-checking bench: link bytes, contention faults, video timing
`timescale 1ns/1ps
`default_nettype none
`define check_eq(act, exp) \
	begin \
		n_checks++; \
		if ((act) !== (exp)) \
		begin \
			errors++; \
			$display("[ERR] %0t got %h expected %h", $time, act, exp); \
		end \
	end
module serial_video_link_rx_timing_bench;
	import link_timing_pkg::*;
	logic         clock = 1'b0;
	logic         rstn = 1'b0;
	logic         free_run = 1'b1;
	wire          link_clock;
	wire          lane_data;
	wire          lane_hs_active;
	lp_drive_type lp_drive = 2'h0;
	logic         above_low = 1'b1;
	logic         above_cont = 1'b0;
	logic         hsync_n = 1'b1;
	logic         vsync_n = 1'b1;
	logic         data_enable = 1'b0;
	logic         clear_faults = 1'b0;
	logic         rx_valid;
	logic         rx_ready = 1'b0;
	logic [7:0]   rx_data;
	fault_type    faults;
	logic         hold = 1'b0;
	logic [7:0]   exp_q[$];
	logic [7:0]   exp_byte;
	logic [7:0]   corner[4] = '{8'h00, 8'hff, 8'h01, 8'h80};
	int           errors = 0;
	int           n_checks = 0;
	int           n;
	// Contention: enable, level, above_low, above_cont, high fault, low fault
	bit           lp_cases[5][6] = '{'{1,1,0,0,1,0}, '{1,0,1,1,0,1}, '{1,1,1,1,0,0}, '{1,0,0,0,0,0}, '{0,1,0,0,0,0}};
	// Frame: vsync, vback, active lines, vfront, sync, back, active, front, error
	int           cases[12][9] = '{'{2,2,4,2,6,15,240,21,0}, '{2,2,4,2,6,61,240,21,0}, '{2,2,4,2,5,16,240,21,1},
		'{2,2,4,2,79,5,240,21,1}, '{2,2,4,2,17,4,240,21,1}, '{2,2,4,2,6,15,239,21,1}, '{2,2,4,2,6,15,240,20,1},
		'{2,2,4,2,6,62,240,21,1}, '{2,2,4,2,6,14,240,21,1}, '{1,3,4,2,6,15,240,21,1}, '{3,1,4,2,6,15,240,21,1},
		'{3,2,3,1,6,15,240,21,1}};

	host_link_model model (.free_run(free_run), .link_clock(link_clock), .lane_data(lane_data),
		.lane_hs_active(lane_hs_active));

	serial_video_link_rx_timing #(.ACTIVE_PIXELS(11'h0f0), .ACTIVE_LINES(11'h004)) dut (.clock(clock), .rstn(rstn),
		.link_clock(link_clock), .lane_data(lane_data), .lane_hs_active(lane_hs_active), .lp_drive(lp_drive),
		.pin_above_low_threshold(above_low), .pin_above_contention(above_cont), .hsync_n(hsync_n),
		.vsync_n(vsync_n), .data_enable(data_enable), .clear_faults(clear_faults), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_data(rx_data), .faults(faults));

	always #12.5 clock = ~clock;

	// Consumer with random stalls
	always @(posedge clock)
	begin
		if (rx_valid === 1'b1 && rx_ready === 1'b1 && !hold)
		begin
			exp_byte = exp_q.pop_front();
			`check_eq(rx_data, exp_byte)
		end
		rx_ready <= hold ? 1'b0 : 1'($urandom % 2);
	end

	task automatic cycles(input int k);
		repeat (k) @(posedge clock);
	endtask

	task automatic results();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic clear();
		clear_faults <= 1'b1;
		cycles(1);
		clear_faults <= 1'b0;
		cycles(1);
	endtask

	task automatic wait_empty();
		for (int i = 0; i < 400 && exp_q.size() > 0; i++)
			cycles(1);
		if (exp_q.size() > 0)
		begin
			errors++;
			$display("[ERR] %0t link bytes not delivered", $time);
			results();
		end
		cycles(2);
	endtask

	task automatic line(input int s, input int b, input int a, input int f, input bit de);
		hsync_n <= 1'b0;
		cycles(s);
		hsync_n <= 1'b1;
		cycles(b);
		data_enable <= de;
		cycles(a);
		data_enable <= 1'b0;
		cycles(f);
	endtask

	// Odd horizontal figures land on the second active line
	task automatic frame(input int c[9]);
		bit bad;
		for (int i = 0; i < c[0] + c[1] + c[2] + c[3]; i++)
		begin
			vsync_n <= (i >= c[0]);
			bad = (i == c[0] + c[1] + 1);
			line(bad ? c[4] : 6, bad ? c[5] : 15, bad ? c[6] : 240, bad ? c[7] : 21,
				i >= c[0] + c[1] && i < c[0] + c[1] + c[2]);
		end
		hsync_n <= 1'b0;
		vsync_n <= 1'b0;
		cycles(3);
	endtask

	initial
	begin
		void'($urandom(32'h4f1950b8));
		cycles(4);
		rstn <= 1'b1;
		cycles(1);
		`check_eq(faults, 4'h0)
		`check_eq(rx_valid, 1'b0)
		cycles(3);
		free_run <= 1'b0;
		cycles(4);
		for (int k = 0; k < 20; k++)
		begin
			n = (k == 0) ? 4 : 1 + $urandom % 4;
			for (int j = 0; j < n; j++)
			begin
				exp_q.push_back((k == 0) ? corner[j] : 8'($urandom));
				model.tx_q.push_back(exp_q[j]);
			end
			model.send_burst();
			wait_empty();
		end
		for (int k = 0; k < 5; k++)
		begin
			// Pin settles before the driver turns on
			above_low <= lp_cases[k][2];
			above_cont <= lp_cases[k][3];
			cycles(6);
			lp_drive <= '{enable: lp_cases[k][0], level: lp_cases[k][1]};
			cycles(8);
			`check_eq(faults.lp_high_fault, lp_cases[k][4])
			`check_eq(faults.lp_low_fault, lp_cases[k][5])
			lp_drive <= 2'h0;
			cycles(8);
			clear();
			`check_eq(faults, 4'h0)
		end
		frame(cases[0]);
		for (int k = 0; k < 12; k++)
		begin
			clear();
			frame(cases[k]);
			`check_eq(faults.timing_error, 1'(cases[k][8]))
		end
		// Stalled consumer: store fills and refuses
		hold <= 1'b1;
		cycles(2);
		repeat (10) model.tx_q.push_back(8'($urandom));
		model.send_burst();
		cycles(20);
		`check_eq(faults.fifo_overflow, 1'b1)
		`check_eq(rx_valid, 1'b1)
		results();
	end
endmodule
`default_nettype wire
